// ===== src/tefs_pkg.sv
// Package with register map, field layout and reset values of the timer event flag block.
package tefs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] TEFS_OFS_CMP_B   = 4'h0;
  localparam logic [3:0] TEFS_OFS_WRAP    = 4'h4;
  localparam logic [3:0] TEFS_OFS_EVT     = 4'h8;
  localparam logic [3:0] TEFS_OFS_MASK    = 4'hC;
  localparam int         TEFS_ADDR_W      = 4;

  // ----------------------------------------------------------------
  // Field layout of both status registers
  // ----------------------------------------------------------------
  localparam int         TEFS_NCH         = 3;
  localparam int         TEFS_FLAG_LSB    = 0;
  localparam int         TEFS_EN_LSB      = 4;
  localparam int         TEFS_RSV_HI      = 7;
  localparam int         TEFS_RSV_LO      = 3;
  localparam int         TEFS_CH_UNDER    = 2;
  localparam logic [7:0] TEFS_STAT_RESET  = 8'h88;
  localparam logic [7:0] TEFS_RSV_MASK    = 8'h88;

  // Sticky event register: bits 2..0 compare-B, bits 5..3 wrap.
  localparam int         TEFS_EVT_W       = 6;
  localparam int         TEFS_EVT_WRAP_LSB = 3;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] TEFS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TEFS_RESP_SLVERR = 2'h2;
  localparam logic [31:0] TEFS_RDATA_ZERO = 32'h0000_0000;

  // Layout of one 8-bit status register.
  typedef struct packed {
    logic       rsv_hi;
    logic [2:0] irq_en;
    logic       rsv_lo;
    logic [2:0] flag;
  } tefs_stat_s;

  // Event inputs of all four kinds, one bit per channel; wrap_down has a single bit.
  typedef struct packed {
    logic [2:0] cmp_match;
    logic [2:0] cmp_capture;
    logic [2:0] wrap_up;
    logic       wrap_down;
  } tefs_evt_s;

endpackage

// ===== src/tefs_top.sv
// Event flag, interrupt enable and AXI4-Lite register logic of a three-channel 16-bit timer.
//
// Operation
// RULE1 - The compare-B status register is 8 bits and becomes 0x88 on reset and on standby entry.
// RULE2 - The counter wrap status register is 8 bits and becomes 0x88 on reset and on standby entry.
// RULE3 - Bits 7 and 3 of both status registers read as 1 and ignore writes.
// RULE4 - Bits 6..4 of the compare-B register enable the compare-B requests of channels 2..0 and reset to 0.
// RULE5 - Bits 2..0 of the compare-B register are the compare-B flags of channels 2..0 and reset to 0.
// RULE6 - A compare-B flag sets when the counter equals general register B in compare use.
// RULE7 - A compare-B flag sets when a capture copies the counter into general register B.
// RULE8 - A compare-B flag clears only when software reads it as 1 and then writes 0 to it.
// RULE9 - Writing 1 to a flag bit leaves it unchanged.
// RULE10 - Bits 6..4 of the wrap register enable the wrap requests of channels 2..0 and reset to 0.
// RULE11 - Each request is high only while its flag and its enable are both 1; here each request is registered and follows them one cycle later.
// RULE12 - The channel 2 wrap flag sets when its counter wraps up or down through 0xFFFF and 0x0000.
// RULE13 - Underflow counts only on channel 2 and only while phase counting is selected.
// RULE14 - The channel 1 and 0 wrap flags set only on an upward wrap from 0xFFFF to 0x0000.
// RULE15 - Wrap flags reset to 0 and clear only when read as 1 and then written 0.
// RULE16 - With the direction bit 0 the channel 2 wrap flag sets on both wraps, with 1 on overflow only.
// RULE17 - A set event in the cycle of a clearing write leaves the flag set.
`timescale 1ns/10ps

module tefs_top
  import tefs_pkg::*;
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   RESETN,
  input  wire logic                   CE,
  input  wire logic                   STANDBY,
  input  wire logic [2:0]             CMP_B_MATCH,
  input  wire logic [2:0]             CMP_B_CAPTURE,
  input  wire logic [2:0]             WRAP_UP,
  input  wire logic                   WRAP_DOWN_CH2,
  input  wire logic                   PHASE_COUNT_SELECT,
  input  wire logic                   WRAP_FLAG_DIRECTION,
  input  wire logic [31:0]            AWADDR,
  input  wire logic [2:0]             AWPROT,
  input  wire logic                   AWVALID,
  output logic                        AWREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  input  wire logic                   WVALID,
  output logic                        WREADY,
  output logic [1:0]                  BRESP,
  output logic                        BVALID,
  input  wire logic                   BREADY,
  input  wire logic [31:0]            ARADDR,
  input  wire logic [2:0]             ARPROT,
  input  wire logic                   ARVALID,
  output logic                        ARREADY,
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  output logic                        RVALID,
  input  wire logic                   RREADY,
  output logic [2:0]                  CMP_B_IRQ,
  output logic [2:0]                  WRAP_IRQ,
  output logic                        IRQ
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function automatic logic [3:0] reg_hit(input logic [31:0] addr);
    logic [3:0] hit;
    hit    = 4'h0;
    if (addr[31:TEFS_ADDR_W] == '0) begin
      hit[0] = (addr[TEFS_ADDR_W-1:0] == TEFS_OFS_CMP_B);
      hit[1] = (addr[TEFS_ADDR_W-1:0] == TEFS_OFS_WRAP);
      hit[2] = (addr[TEFS_ADDR_W-1:0] == TEFS_OFS_EVT);
      hit[3] = (addr[TEFS_ADDR_W-1:0] == TEFS_OFS_MASK);
    end
    return hit;
  endfunction

  logic                  awready_q, awready_d;
  logic                  wready_q,  wready_d;
  logic                  bvalid_q,  bvalid_d;
  logic [1:0]            bresp_q,   bresp_d;
  logic                  arready_q, arready_d;
  logic                  rvalid_q,  rvalid_d;
  logic [1:0]            rresp_q,   rresp_d;
  logic [31:0]           rdata_q,   rdata_d;
  logic [31:0]           awaddr_q;
  logic [31:0]           wdata_q;
  logic [3:0]            wstrb_q;
  logic [3:0]            rd_sel_q;

  wire aw_fire   = AWVALID & awready_q;
  wire w_fire    = WVALID & wready_q;
  wire ar_fire   = ARVALID & arready_q;
  wire wr_go     = ~awready_q & ~wready_q & ~bvalid_q;
  wire [3:0] wr_hit = reg_hit(awaddr_q) & {4{wr_go & wstrb_q[0]}};
  wire [3:0] rd_hit = reg_hit(ARADDR) & {4{ar_fire}};
  wire wr_mapped = (reg_hit(awaddr_q) != 4'h0);
  wire [3:0] wr_dec = reg_hit(awaddr_q);
  wire rd_mapped = (reg_hit(ARADDR) != 4'h0);

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------
  logic [2:0] cmp_flag_q, cmp_flag_d, cmp_arm_q, cmp_arm_d, cmp_en_q, cmp_en_d;
  logic [2:0] wrap_flag_q, wrap_flag_d, wrap_arm_q, wrap_arm_d, wrap_en_q, wrap_en_d;
  logic [2:0] cmp_set, wrap_set, cmp_clr, wrap_clr;
  logic [TEFS_EVT_W-1:0] evt_q, evt_d, mask_q, mask_d;
  logic [2:0] cmp_irq_q, wrap_irq_q;
  logic       irq_q;
  tefs_stat_s cmp_view, wrap_view;

  // Underflow only exists in phase counting mode and is dropped when the direction bit asks for overflow only.
  wire under_ok = WRAP_DOWN_CH2 & PHASE_COUNT_SELECT & ~WRAP_FLAG_DIRECTION;  // [RULE13] [RULE16]

  genvar g;
  generate
    for (g = 0; g < TEFS_NCH; g++) begin : g_ch
      assign cmp_set[g]  = CMP_B_MATCH[g] | CMP_B_CAPTURE[g];  // [RULE6] [RULE7]
      if (g == TEFS_CH_UNDER) begin : g_up_down
        assign wrap_set[g] = WRAP_UP[g] | under_ok;  // [RULE12]
      end else begin : g_up_only
        assign wrap_set[g] = WRAP_UP[g];  // [RULE14]
      end
      // A written 0 clears only a flag that was read as 1 before; a written 1 never touches it.
      assign cmp_clr[g]  = wr_hit[0] & ~wdata_q[TEFS_FLAG_LSB+g] & cmp_arm_q[g];  // [RULE8] [RULE9]
      assign wrap_clr[g] = wr_hit[1] & ~wdata_q[TEFS_FLAG_LSB+g] & wrap_arm_q[g];  // [RULE15] [RULE9]
      // The set term is ORed last so an event beats a clear in the same cycle.
      assign cmp_flag_d[g]  = cmp_set[g] | (cmp_flag_q[g] & ~cmp_clr[g]);  // [RULE17]
      assign wrap_flag_d[g] = wrap_set[g] | (wrap_flag_q[g] & ~wrap_clr[g]);  // [RULE17]
      // Any write to the register ends the read-then-write pairing.
      assign cmp_arm_d[g]  = rd_hit[0] ? cmp_flag_q[g] : (wr_go & wr_dec[0]) ? 1'b0 : cmp_arm_q[g];
      assign wrap_arm_d[g] = rd_hit[1] ? wrap_flag_q[g] : (wr_go & wr_dec[1]) ? 1'b0 : wrap_arm_q[g];
    end
  endgenerate

  assign cmp_en_d  = wr_hit[0] ? wdata_q[TEFS_EN_LSB +: 3] : cmp_en_q;  // [RULE4]
  assign wrap_en_d = wr_hit[1] ? wdata_q[TEFS_EN_LSB +: 3] : wrap_en_q;  // [RULE10]

  // Reserved positions are constants in the read view, so writes cannot reach them.
  assign cmp_view  = '{rsv_hi: 1'b1, irq_en: cmp_en_q, rsv_lo: 1'b1, flag: cmp_flag_q};  // [RULE3]
  assign wrap_view = '{rsv_hi: 1'b1, irq_en: wrap_en_q, rsv_lo: 1'b1, flag: wrap_flag_q};  // [RULE3]

  // ----------------------------------------------------------------
  // Sticky event status and mask for the summary interrupt
  // ----------------------------------------------------------------
  wire [TEFS_EVT_W-1:0] evt_in  = {wrap_set, cmp_set};
  wire [TEFS_EVT_W-1:0] evt_w1c = wr_hit[2] ? wdata_q[TEFS_EVT_W-1:0] : '0;
  assign evt_d  = evt_in | (evt_q & ~evt_w1c);
  assign mask_d = wr_hit[3] ? wdata_q[TEFS_EVT_W-1:0] : mask_q;

  // ----------------------------------------------------------------
  // AXI4-Lite channel control
  // ----------------------------------------------------------------
  wire b_done = bvalid_q & BREADY;
  wire r_done = rvalid_q & RREADY;

  assign awready_d = aw_fire ? 1'b0 : (b_done ? 1'b1 : awready_q);
  assign wready_d  = w_fire ? 1'b0 : (b_done ? 1'b1 : wready_q);
  assign bvalid_d  = wr_go ? 1'b1 : (b_done ? 1'b0 : bvalid_q);
  assign bresp_d   = wr_go ? (wr_mapped ? TEFS_RESP_OKAY : TEFS_RESP_SLVERR) : bresp_q;
  assign arready_d = ar_fire ? 1'b0 : (r_done ? 1'b1 : arready_q);
  assign rvalid_d  = ar_fire ? 1'b1 : (r_done ? 1'b0 : rvalid_q);
  assign rresp_d   = ar_fire ? (rd_mapped ? TEFS_RESP_OKAY : TEFS_RESP_SLVERR) : rresp_q;

  wire [31:0] rd_mux = rd_hit[0] ? {24'h00_0000, cmp_view} :
                       rd_hit[1] ? {24'h00_0000, wrap_view} :
                       rd_hit[2] ? {26'h000_0000, evt_q} :
                       rd_hit[3] ? {26'h000_0000, mask_q} : TEFS_RDATA_ZERO;
  assign rdata_d = ar_fire ? rd_mux : rdata_q;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= TEFS_RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= TEFS_RESP_OKAY;
      rdata_q   <= TEFS_RDATA_ZERO;
      awaddr_q  <= 32'h0000_0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      rd_sel_q  <= 4'h0;
    end else if (CE) begin
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      if (aw_fire) begin
        awaddr_q <= AWADDR;
      end
      if (w_fire) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (ar_fire) begin
        rd_sel_q <= rd_hit;
      end
    end
  end

  // Reset and standby both return the status registers to their initial state.
  always_ff @(posedge CLK_SYS) begin
    if (!RESETN || (CE && STANDBY)) begin
      cmp_flag_q  <= TEFS_STAT_RESET[TEFS_FLAG_LSB +: 3];  // [RULE1] [RULE5]
      cmp_en_q    <= TEFS_STAT_RESET[TEFS_EN_LSB +: 3];  // [RULE1] [RULE4]
      cmp_arm_q   <= 3'h0;
      wrap_flag_q <= TEFS_STAT_RESET[TEFS_FLAG_LSB +: 3];  // [RULE2] [RULE15]
      wrap_en_q   <= TEFS_STAT_RESET[TEFS_EN_LSB +: 3];  // [RULE2] [RULE10]
      wrap_arm_q  <= 3'h0;
    end else if (CE) begin
      cmp_flag_q  <= cmp_flag_d;
      cmp_en_q    <= cmp_en_d;
      cmp_arm_q   <= cmp_arm_d;
      wrap_flag_q <= wrap_flag_d;
      wrap_en_q   <= wrap_en_d;
      wrap_arm_q  <= wrap_arm_d;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESETN) begin
      evt_q      <= '0;
      mask_q     <= '0;
      cmp_irq_q  <= 3'h0;
      wrap_irq_q <= 3'h0;
      irq_q      <= 1'b0;
    end else if (CE) begin
      evt_q      <= evt_d;
      mask_q     <= mask_d;
      cmp_irq_q  <= cmp_flag_q & cmp_en_q;  // [RULE11]
      wrap_irq_q <= wrap_flag_q & wrap_en_q;  // [RULE11]
      irq_q      <= |(evt_q & mask_q);
    end
  end

  assign AWREADY   = awready_q;
  assign WREADY    = wready_q;
  assign BVALID    = bvalid_q;
  assign BRESP     = bresp_q;
  assign ARREADY   = arready_q;
  assign RVALID    = rvalid_q;
  assign RRESP     = rresp_q;
  assign RDATA     = rdata_q;
  assign CMP_B_IRQ = cmp_irq_q;
  assign WRAP_IRQ  = wrap_irq_q;
  assign IRQ       = irq_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  a_cmp_flag_set: assert property ((CE && !STANDBY && cmp_set != 3'h0) |=> // [RULE6]
    ((cmp_flag_q & $past(cmp_set)) == $past(cmp_set)))
    else $error("compare-B event did not set its flag");

  a_wrap_flag_set: assert property ((CE && !STANDBY && WRAP_UP != 3'h0) |=> // [RULE14]
    ((wrap_flag_q & $past(WRAP_UP)) == $past(WRAP_UP)))
    else $error("upward wrap did not set its flag");

  a_unarmed_no_clear: assert property ((CE && !STANDBY && wr_hit[0]) |=> // [RULE8]
    ((cmp_flag_q & $past(cmp_flag_q & ~cmp_arm_q)) == $past(cmp_flag_q & ~cmp_arm_q)))
    else $error("compare-B flag cleared without a prior read");

  a_armed_clear: assert property ((CE && !STANDBY && wr_hit[1] && wrap_clr != 3'h0 && wrap_set == 3'h0) |=> // [RULE15]
    ((wrap_flag_q & $past(wrap_clr)) == 3'h0))
    else $error("wrap flag not cleared after read and write of 0");

  a_one_keeps_flag: assert property ((CE && !STANDBY && wr_hit[0] && cmp_flag_q != 3'h0) |=> // [RULE9]
    ((cmp_flag_q & $past(cmp_flag_q & wdata_q[2:0])) == $past(cmp_flag_q & wdata_q[2:0])))
    else $error("writing 1 changed a compare-B flag");

  a_under_gated: assert property ((CE && !STANDBY && WRAP_DOWN_CH2 && !WRAP_UP[2] && !wrap_flag_q[2] // [RULE13]
    && (!PHASE_COUNT_SELECT || WRAP_FLAG_DIRECTION)) |=> !wrap_flag_q[2])
    else $error("underflow set the flag outside its mode");

  a_under_sets: assert property ((CE && !STANDBY && under_ok) |=> wrap_flag_q[2]) // [RULE16]
    else $error("accepted underflow did not set the channel 2 flag");

  a_irq_follows: assert property ((CE && !STANDBY) ##1 CE |=> // [RULE11]
    (CMP_B_IRQ == $past(cmp_flag_q & cmp_en_q, 1)) && (WRAP_IRQ == $past(wrap_flag_q & wrap_en_q, 1)))
    else $error("request does not follow flag and enable");

  a_standby_init: assert property ((CE && STANDBY) |=> // [RULE1] [RULE2]
    ({cmp_en_q, cmp_flag_q, wrap_en_q, wrap_flag_q} == 12'h000))
    else $error("standby did not initialise status registers");

  a_rsv_read_one: assert property ((RVALID && (rd_sel_q[0] || rd_sel_q[1])) |-> // [RULE3]
    ((RDATA[7:0] & TEFS_RSV_MASK) == TEFS_RSV_MASK))
    else $error("reserved status bits did not read as 1");

  a_bvalid_hold: assert property ((BVALID && !BREADY) |=> BVALID)
    else $error("write response dropped before it was taken");

  // ----------------------------------------------------------------
  // Bus answer checks
  // ----------------------------------------------------------------
  a_write_answer: assert property ((CE && wr_go) |=> BVALID)
    else $error("write response missing after write");

  a_write_slverr: assert property ((CE && wr_go && !wr_mapped) |=> (BRESP == TEFS_RESP_SLVERR))
    else $error("unmapped write was not refused");

  a_read_answer: assert property ((CE && ARVALID && ARREADY) |=> RVALID)
    else $error("read data missing after address");

  a_rvalid_hold: assert property ((RVALID && !RREADY) |=> (RVALID && $stable(RDATA)))
    else $error("read data dropped before it was taken");

  // ----------------------------------------------------------------
  // Further status register checks
  // ----------------------------------------------------------------
  a_cmp_en_write: assert property ((CE && !STANDBY && wr_hit[0]) |=> // [RULE4]
    (cmp_en_q == $past(wdata_q[TEFS_EN_LSB +: 3])))
    else $error("compare-B enables not written");

  a_wrap_en_write: assert property ((CE && !STANDBY && wr_hit[1]) |=> // [RULE10]
    (wrap_en_q == $past(wdata_q[TEFS_EN_LSB +: 3])))
    else $error("wrap enables not written");

  a_capture_sets: assert property ((CE && !STANDBY && CMP_B_CAPTURE != 3'h0) |=> // [RULE7]
    ((cmp_flag_q & $past(CMP_B_CAPTURE)) == $past(CMP_B_CAPTURE)))
    else $error("capture did not set its flag");

  a_wrap_up_ch2: assert property ((CE && !STANDBY && WRAP_UP[2]) |=> wrap_flag_q[2]) // [RULE12]
    else $error("channel 2 overflow did not set its flag");

  a_low_up_only: assert property ((CE && !STANDBY && WRAP_UP[1:0] == 2'b00) |=> // [RULE14]
    ((wrap_flag_q[1:0] & ~$past(wrap_flag_q[1:0])) == 2'b00))
    else $error("channel 0 or 1 flag set without overflow");

  a_cmp_arm_read: assert property ((CE && !STANDBY && rd_hit[0]) |=> (cmp_arm_q == $past(cmp_flag_q))) // [RULE8]
    else $error("read did not record the set compare-B flags");

  a_wrap_arm_read: assert property ((CE && !STANDBY && rd_hit[1]) |=> (wrap_arm_q == $past(wrap_flag_q))) // [RULE15]
    else $error("read did not record the set wrap flags");

  a_cmp_clear: assert property ((CE && !STANDBY && cmp_clr != 3'h0 && cmp_set == 3'h0) |=> // [RULE8]
    ((cmp_flag_q & $past(cmp_clr)) == 3'h0))
    else $error("compare-B flag not cleared after read and write of 0");

  a_wrap_unarmed: assert property ((CE && !STANDBY && wr_hit[1]) |=> // [RULE15]
    ((wrap_flag_q & $past(wrap_flag_q & ~wrap_arm_q)) == $past(wrap_flag_q & ~wrap_arm_q)))
    else $error("wrap flag cleared without a prior read");

  a_wrap_one_keeps: assert property ((CE && !STANDBY && wr_hit[1]) |=> // [RULE9]
    ((wrap_flag_q & $past(wrap_flag_q & wdata_q[2:0])) == $past(wrap_flag_q & wdata_q[2:0])))
    else $error("writing 1 changed a wrap flag");

  a_wrap_set_wins: assert property ((CE && !STANDBY && wrap_set != 3'h0) |=> // [RULE17]
    ((wrap_flag_q & $past(wrap_set)) == $past(wrap_set)))
    else $error("wrap event lost against a clear");

  a_evt_sticky: assert property ((CE && evt_in != '0) |=> ((evt_q & $past(evt_in)) == $past(evt_in)))
    else $error("event did not set its sticky bit");

  a_irq_summary: assert property (CE |=> (IRQ == $past(|(evt_q & mask_q)))) // [RULE11]
    else $error("summary request does not follow events and mask");

  c_flag_clear: cover property (CE && wr_hit[0] && cmp_clr != 3'h0);
  c_set_beats_clear: cover property (CE && (wrap_clr & wrap_set) != 3'h0);
  c_underflow: cover property (CE && under_ok);
  c_irq_rise: cover property (!IRQ ##1 IRQ);
  c_standby: cover property (CE && STANDBY && cmp_flag_q != 3'h0);

endmodule

// ===== tb/tefs_cpu_model.sv
// Software side model: AXI4-Lite master tasks used by the testbench.
`timescale 1ns/10ps

module tefs_cpu_model (
  input  wire logic        clk,
  output logic [31:0]      awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [31:0]      araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  // Address and data are offered together; each is released at its own handshake.
  task automatic write(input logic [31:0] addr, input logic [31:0] data, output logic [1:0] resp);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= addr;
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic read(input logic [31:0] addr, output logic [31:0] data, output logic [1:0] resp);
    @(posedge clk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

// ===== tb/tefs_top_tb.sv
// Self-checking testbench of the timer event flag block.
`timescale 1ns/10ps

module tefs_top_tb
  import tefs_pkg::*;
;
  localparam logic [31:0] A_CMP  = {28'h000_0000, TEFS_OFS_CMP_B};
  localparam logic [31:0] A_WRAP = {28'h000_0000, TEFS_OFS_WRAP};
  localparam logic [31:0] A_EVT  = {28'h000_0000, TEFS_OFS_EVT};
  localparam logic [31:0] A_MASK = {28'h000_0000, TEFS_OFS_MASK};

  logic        clk_sys, resetn, standby, wrap_down, phase_sel, flag_dir, ce;
  logic [2:0]  cmp_match, cmp_capture, wrap_up, cmp_b_irq, wrap_irq;
  logic        irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          num_errors = 0;
  int          comparisons = 0;

  tefs_cpu_model u_tefs_cpu_model (.clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  tefs_top u_tefs_top (.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce), .STANDBY(standby),
    .CMP_B_MATCH(cmp_match), .CMP_B_CAPTURE(cmp_capture), .WRAP_UP(wrap_up), .WRAP_DOWN_CH2(wrap_down),
    .PHASE_COUNT_SELECT(phase_sel), .WRAP_FLAG_DIRECTION(flag_dir), .AWADDR(awaddr), .AWPROT(3'h0),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .CMP_B_IRQ(cmp_b_irq), .WRAP_IRQ(wrap_irq), .IRQ(irq));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("Checks: %0d, mismatches: %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data, input logic [1:0] exp_resp);
    logic [1:0] resp;
    u_tefs_cpu_model.write(addr, data, resp);
    check("write response", {30'h0, exp_resp}, {30'h0, resp});
  endtask

  task automatic rd(input string name, input logic [31:0] addr, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] data;
    logic [1:0]  resp;
    u_tefs_cpu_model.read(addr, data, resp);
    check(name, exp, data);
    check("read response", {30'h0, er}, {30'h0, resp});
  endtask

  // Drives one cycle of event pulses.
  task automatic evt(input logic [2:0] m, input logic [2:0] c, input logic [2:0] u, input logic d);
    @(posedge clk_sys);
    {cmp_match, cmp_capture, wrap_up, wrap_down} <= {m, c, u, d};
    @(posedge clk_sys);
    {cmp_match, cmp_capture, wrap_up, wrap_down} <= '0;
    repeat (2) @(posedge clk_sys);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    summarize();
  end

  initial begin
    resetn = 1'b0;
    {standby, cmp_match, cmp_capture, wrap_up, wrap_down, phase_sel, flag_dir} = '0;
    ce = 1'b1;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd("cmp_b reset", A_CMP, 32'h0000_0088, TEFS_RESP_OKAY);
    rd("wrap reset", A_WRAP, 32'h0000_0088, TEFS_RESP_OKAY);
    wr(A_CMP, 32'h0000_00FF, TEFS_RESP_OKAY);
    rd("cmp_b enables", A_CMP, 32'h0000_00F8, TEFS_RESP_OKAY);
    wr(A_WRAP, 32'h0000_0077, TEFS_RESP_OKAY);
    rd("wrap enables", A_WRAP, 32'h0000_00F8, TEFS_RESP_OKAY);
    evt(3'b001, 3'b010, 3'b000, 1'b0);
    rd("cmp_b flags", A_CMP, 32'h0000_00FB, TEFS_RESP_OKAY);
    check("cmp_b irq", {29'h0, cmp_b_irq}, 32'h0000_0003);
    wr(A_CMP, 32'h0000_00FF, TEFS_RESP_OKAY);
    wr(A_CMP, 32'h0000_00F0, TEFS_RESP_OKAY);
    rd("cmp_b no read", A_CMP, 32'h0000_00FB, TEFS_RESP_OKAY);
    wr(A_CMP, 32'h0000_00F0, TEFS_RESP_OKAY);
    rd("cmp_b cleared", A_CMP, 32'h0000_00F8, TEFS_RESP_OKAY);
    check("cmp_b irq off", {29'h0, cmp_b_irq}, 32'h0000_0000);
    wr(A_CMP, 32'h0000_0000, TEFS_RESP_OKAY);
    evt(3'b100, 3'b000, 3'b000, 1'b0);
    rd("cmp_b masked", A_CMP, 32'h0000_008C, TEFS_RESP_OKAY);
    check("cmp_b irq masked", {29'h0, cmp_b_irq}, 32'h0000_0000);
    // A match pulse in the very cycle in which the clearing write lands keeps the flag set.
    fork
      wr(A_CMP, 32'h0000_0000, TEFS_RESP_OKAY);
      begin
        repeat (2) @(posedge clk_sys);
        cmp_match <= 3'b100;
        @(posedge clk_sys);
        cmp_match <= 3'b000;
      end
    join
    rd("cmp_b set wins", A_CMP, 32'h0000_008C, TEFS_RESP_OKAY);
    evt(3'b000, 3'b000, 3'b011, 1'b1);
    rd("wrap up only", A_WRAP, 32'h0000_00FB, TEFS_RESP_OKAY);
    check("wrap irq", {29'h0, wrap_irq}, 32'h0000_0003);
    @(posedge clk_sys);
    {phase_sel, flag_dir} <= 2'b11;
    evt(3'b000, 3'b000, 3'b000, 1'b1);
    rd("wrap dir up", A_WRAP, 32'h0000_00FB, TEFS_RESP_OKAY);
    flag_dir <= 1'b0;
    evt(3'b000, 3'b000, 3'b000, 1'b1);
    rd("wrap underflow", A_WRAP, 32'h0000_00FF, TEFS_RESP_OKAY);
    check("wrap irq all", {29'h0, wrap_irq}, 32'h0000_0007);
    wr(A_WRAP, 32'h0000_0070, TEFS_RESP_OKAY);
    rd("wrap cleared", A_WRAP, 32'h0000_00F8, TEFS_RESP_OKAY);
    evt(3'b000, 3'b000, 3'b100, 1'b0);
    rd("wrap up ch2", A_WRAP, 32'h0000_00FC, TEFS_RESP_OKAY);
    check("wrap irq ch2", {29'h0, wrap_irq}, 32'h0000_0004);
    rd("event status", A_EVT, 32'h0000_003F, TEFS_RESP_OKAY);
    check("irq masked", {31'h0, irq}, 32'h0000_0000);
    wr(A_MASK, 32'h0000_0001, TEFS_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    check("irq on", {31'h0, irq}, 32'h0000_0001);
    wr(A_EVT, 32'h0000_0001, TEFS_RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    check("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rd("event after clear", A_EVT, 32'h0000_003E, TEFS_RESP_OKAY);
    rd("unmapped read", 32'h0000_0010, TEFS_RDATA_ZERO, TEFS_RESP_SLVERR);
    wr(32'h0000_0010, 32'h0000_00FF, TEFS_RESP_SLVERR);
    @(posedge clk_sys);
    standby <= 1'b1;
    repeat (2) @(posedge clk_sys);
    standby <= 1'b0;
    rd("cmp_b standby", A_CMP, 32'h0000_0088, TEFS_RESP_OKAY);
    rd("wrap standby", A_WRAP, 32'h0000_0088, TEFS_RESP_OKAY);
    ce <= 1'b0;
    evt(3'b001, 3'b000, 3'b000, 1'b0);
    ce <= 1'b1;
    rd("cmp_b frozen", A_CMP, 32'h0000_0088, TEFS_RESP_OKAY);
    summarize();
  end
endmodule
